/* File: rtl/rtc_counter.sv */
/*
 * Real-time counter with compare and wrap flags, plus a periodic tick timer sharing one 15-bit prescaler.
 * Assumes the oscillator levels arrive synchronous to mclk and much slower than it; software is the only partner.
 */
// Added by the designer: the AXI4-Lite slave port and the address map.
//
// Overview of operation
// - Selected reference clock passes a fifteen-bit prescaler before reaching the counter.
// - First counter tick after counter equals match value raises match flag and event.
// - First counter tick after counter equals wrap limit raises wrap flag and event.
// - On wrap the counter returns to zero.
// - Four clock sources: crystal, external clock, ultra-low-power oscillator, oscillator divided by 32.
// - Periodic timer raises an interrupt every 2^n counter clocks, 4 to 32768.
// - Periodic timer offers level events dividing by 64 up to 8192.
// - Periodic timer works whether or not the counter is enabled.
// - Counter and periodic timer take timing from one shared prescaler counter.
// - The clock source selection serves both counter and periodic timer.
// - Busy bits report pending slow-domain synchronisation; software checks them before writing.
// - Counter enable written 1 starts the counter, written 0 stops it.
// - Periodic timer enable written 1 starts it, written 0 stops it.
// - Counter keeps running in sleep and its interrupts can wake the device.
// - Prescaler halts when both enables are 0 and counts when either is set.
// - Periodic output toggles every half period after its first interrupt.
// - Wrap and match events fire under exactly the conditions that set the flags.
`timescale 1ns/1ps
module rtc_counter (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic xtal_clk,
    input wire logic ext_clk,
    input wire logic ultra_low_power_osc,
    input wire logic [rtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic counter_irq,
    output logic periodic_irq,
    output logic wrap_event,
    output logic match_event,
    output logic periodic_out,
    output logic [rtc_pkg::EVT_N-1:0] periodic_level_evt
);
    import rtc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] osc_prev;
        logic [ULP_DIV_W-1:0] ulp_div;
        clock_source_t src;
        logic [PRESC_W-1:0] presc;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] wrap_limit;
        logic [CNT_W-1:0] match_value;
        logic counter_enable_bit;
        logic [3:0] presc_sel;
        logic [1:0] irq_en;
        logic [1:0] flags;
        logic periodic_timer_enable_bit;
        logic [3:0] period_sel;
        logic periodic_irq_enable;
        logic periodic_flag;
        logic busy;
        logic periodic_busy;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic counter_irq;
        logic periodic_irq;
        logic wrap_event;
        logic match_event;
        logic periodic_out;
        logic [EVT_N-1:0] level_evt;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                 input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic [PRESC_W-1:0] low_mask(input logic [3:0] n);
        return PRESC_W'((16'h0001 << n) - 16'h0001);
    endfunction : low_mask

    // Period codes 1..14 tap prescaler bit 1..14, i.e. periods of 4 to 32768 clocks.
    function automatic logic tap_bit(input logic [PRESC_W-1:0] p, input logic [3:0] sel);
        logic r;
        r = 1'b0;
        if (sel != 4'h0 && sel != 4'hf) begin
            r = p[sel];
        end
        return r;
    endfunction : tap_bit

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] osc_now;
        logic [2:0] rise;
        logic src_tick;
        logic run;
        logic cnt_tick;
        logic [1:0] hw_set;
        logic [1:0] sw_clr;
        logic periodic_set;
        logic periodic_clr;
        logic do_write;
        logic [31:0] old_word;
        logic [31:0] word;
        logic wr_hit;
        logic [31:0] rd_word;
        logic rd_hit;
        nxt_st = st_ff;
        osc_now = {ultra_low_power_osc, ext_clk, xtal_clk};
        rise = osc_now & ~st_ff.osc_prev;
        src_tick = 1'b0;
        hw_set = 2'h0;
        sw_clr = 2'h0;
        periodic_set = 1'b0;
        periodic_clr = 1'b0;
        cnt_tick = 1'b0;
        old_word = 32'h0000_0000;
        wr_hit = 1'b1;
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        run = 1'b0;
        do_write = 1'b0;
        word = 32'h0000_0000;
        nxt_st.osc_prev = osc_now;

        // One source edge forms the counter clock for both functions.
        if (rise[2]) begin
            nxt_st.ulp_div = st_ff.ulp_div + ULP_DIV_W'(1);
        end
        unique case (st_ff.src)
            SRC_XTAL_32K: src_tick = rise[0];
            SRC_EXT_CLOCK: src_tick = rise[1];
            SRC_ULP_OSC: src_tick = rise[2];
            SRC_ULP_OSC_DIV32: src_tick = rise[2] && st_ff.ulp_div == ULP_DIV_LAST;
        endcase

        // The prescaler keeps its phase while halted, so the first tick after enabling may come early.
        run = st_ff.counter_enable_bit || st_ff.periodic_timer_enable_bit;
        if (run && src_tick) begin
            nxt_st.presc = st_ff.presc + PRESC_W'(1);
            cnt_tick = (st_ff.presc & low_mask(st_ff.presc_sel)) == low_mask(st_ff.presc_sel);
        end

        // Compare and wrap act on the tick that follows the counter holding the value.
        nxt_st.wrap_event = 1'b0;
        nxt_st.match_event = 1'b0;
        if (cnt_tick && st_ff.counter_enable_bit) begin
            if (st_ff.count == st_ff.wrap_limit) begin
                nxt_st.count = '0;
                hw_set[WRAP_BIT] = 1'b1;
            end else begin
                nxt_st.count = st_ff.count + CNT_W'(1);
            end
            hw_set[MATCH_BIT] = st_ff.count == st_ff.match_value;
        end
        nxt_st.wrap_event = hw_set[WRAP_BIT];
        nxt_st.match_event = hw_set[MATCH_BIT];

        // Periodic output follows the tapped prescaler bit; its rising edge is the interrupt.
        nxt_st.periodic_out = st_ff.periodic_timer_enable_bit && tap_bit(nxt_st.presc, st_ff.period_sel);
        periodic_set = nxt_st.periodic_out && !st_ff.periodic_out;
        nxt_st.level_evt = st_ff.periodic_timer_enable_bit ? nxt_st.presc[EVT_LSB_TAP +: EVT_N] : '0;

        // Busy clears on the next counter-clock edge, which is when the slow side would have caught up.
        if (src_tick) begin
            nxt_st.busy = 1'b0;
            nxt_st.periodic_busy = 1'b0;
        end

        // --------------------------------------------------------------
        // AXI4-Lite write path
        // --------------------------------------------------------------
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
            nxt_st.wready = 1'b0;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
        if (do_write) begin
            unique case (st_ff.aw_addr)
                OFS_CONTROL_A: old_word = 32'({st_ff.presc_sel, 2'h0, st_ff.counter_enable_bit});
                OFS_IRQ_CONTROL: old_word = 32'(st_ff.irq_en);
                OFS_CLOCK_SOURCE_SELECT: old_word = 32'(st_ff.src);
                OFS_COUNT: old_word = 32'(st_ff.count);
                OFS_WRAP_LIMIT: old_word = 32'(st_ff.wrap_limit);
                OFS_MATCH_VALUE: old_word = 32'(st_ff.match_value);
                OFS_PERIODIC_TIMER_CONTROL: old_word = 32'({st_ff.period_sel, 2'h0, st_ff.periodic_timer_enable_bit});
                OFS_PERIODIC_IRQ_CONTROL: old_word = 32'(st_ff.periodic_irq_enable);
                default: old_word = 32'h0000_0000;
            endcase
            word = merge_bytes(old_word, st_ff.wdata, st_ff.wstrb);
            unique case (st_ff.aw_addr)
                OFS_CONTROL_A: begin
                    nxt_st.counter_enable_bit = word[EN_BIT];
                    nxt_st.presc_sel = word[FIELD_LSB +: 4];
                    nxt_st.busy = 1'b1;
                end
                OFS_IRQ_CONTROL: nxt_st.irq_en = word[1:0];
                OFS_IRQ_FLAGS: sw_clr = word[1:0] & {2{st_ff.wstrb[0]}};
                OFS_CLOCK_SOURCE_SELECT: nxt_st.src = clock_source_t'(word[1:0]);
                OFS_COUNT: begin
                    nxt_st.count = word[CNT_W-1:0];
                    nxt_st.busy = 1'b1;
                end
                OFS_WRAP_LIMIT: begin
                    nxt_st.wrap_limit = word[CNT_W-1:0];
                    nxt_st.busy = 1'b1;
                end
                OFS_MATCH_VALUE: begin
                    nxt_st.match_value = word[CNT_W-1:0];
                    nxt_st.busy = 1'b1;
                end
                OFS_PERIODIC_TIMER_CONTROL: begin
                    nxt_st.periodic_timer_enable_bit = word[EN_BIT];
                    nxt_st.period_sel = word[FIELD_LSB +: 4];
                    nxt_st.periodic_busy = 1'b1;
                end
                OFS_PERIODIC_IRQ_CONTROL: nxt_st.periodic_irq_enable = word[0];
                OFS_PERIODIC_IRQ_FLAGS: periodic_clr = word[0] && st_ff.wstrb[0];
                OFS_SYNC_STATUS, OFS_PERIODIC_TIMER_SYNC_STATUS: wr_hit = 1'b1;
                default: wr_hit = 1'b0;
            endcase
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end

        // A set in the same cycle as a clear wins, so no event is lost.
        nxt_st.flags = (st_ff.flags & ~sw_clr) | hw_set;
        nxt_st.periodic_flag = (st_ff.periodic_flag && !periodic_clr) || periodic_set;
        // No clock gating here: the request stays live in sleep and serves as the wake source.
        nxt_st.counter_irq = |(nxt_st.flags & nxt_st.irq_en);
        nxt_st.periodic_irq = nxt_st.periodic_flag && nxt_st.periodic_irq_enable;

        // --------------------------------------------------------------
        // AXI4-Lite read path
        // --------------------------------------------------------------
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            unique case (s_axi_araddr)
                OFS_CONTROL_A: rd_word = 32'({st_ff.presc_sel, 2'h0, st_ff.counter_enable_bit});
                OFS_SYNC_STATUS: rd_word = 32'(st_ff.busy);
                OFS_IRQ_CONTROL: rd_word = 32'(st_ff.irq_en);
                OFS_IRQ_FLAGS: rd_word = 32'(st_ff.flags);
                OFS_CLOCK_SOURCE_SELECT: rd_word = 32'(st_ff.src);
                OFS_COUNT: rd_word = 32'(st_ff.count);
                OFS_WRAP_LIMIT: rd_word = 32'(st_ff.wrap_limit);
                OFS_MATCH_VALUE: rd_word = 32'(st_ff.match_value);
                OFS_PERIODIC_TIMER_CONTROL: rd_word = 32'({st_ff.period_sel, 2'h0, st_ff.periodic_timer_enable_bit});
                OFS_PERIODIC_TIMER_SYNC_STATUS: rd_word = 32'(st_ff.periodic_busy);
                OFS_PERIODIC_IRQ_CONTROL: rd_word = 32'(st_ff.periodic_irq_enable);
                OFS_PERIODIC_IRQ_FLAGS: rd_word = 32'(st_ff.periodic_flag);
                default: rd_hit = 1'b0;
            endcase
            nxt_st.rdata = rd_word;
            nxt_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
            nxt_st.rvalid = 1'b1;
            nxt_st.arready = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.wrap_limit <= WRAP_LIMIT_RESET;
            st_ff.match_value <= MATCH_VALUE_RESET;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign counter_irq = st_ff.counter_irq;
    assign periodic_irq = st_ff.periodic_irq;
    assign wrap_event = st_ff.wrap_event;
    assign match_event = st_ff.match_event;
    assign periodic_out = st_ff.periodic_out;
    assign periodic_level_evt = st_ff.level_evt;

endmodule : rtc_counter

/* File: rtl/rtc_pkg.sv */
/*
 * Constants, register map and mode types of the real-time counter with its periodic tick timer.
 * Assumes a single 10 MHz system clock and a 32-bit AXI4-Lite register port.
 */
package rtc_pkg;

    // ------------------------------------------------------------------
    // Widths and clock figures
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int PRESC_W = 15;
    localparam int CNT_W = 16;
    localparam int EVT_N = 8;
    localparam int ULP_DIV_W = 5;
    localparam logic [ULP_DIV_W-1:0] ULP_DIV_LAST = 5'h1f;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONTROL_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SYNC_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CLOCK_SOURCE_SELECT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_WRAP_LIMIT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MATCH_VALUE = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_PERIODIC_TIMER_CONTROL = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_PERIODIC_TIMER_SYNC_STATUS = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_PERIODIC_IRQ_CONTROL = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_PERIODIC_IRQ_FLAGS = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int EN_BIT = 0;
    localparam int FIELD_LSB = 3;
    localparam int WRAP_BIT = 0;
    localparam int MATCH_BIT = 1;
    localparam int EVT_LSB_TAP = 5;
    localparam logic [CNT_W-1:0] WRAP_LIMIT_RESET = 16'hffff;
    localparam logic [CNT_W-1:0] MATCH_VALUE_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_XTAL_32K,
        SRC_EXT_CLOCK,
        SRC_ULP_OSC,
        SRC_ULP_OSC_DIV32
    } clock_source_t;

endpackage : rtc_pkg

/* File: sim/rtc_counter_asserts.sv */
/*
 * Port-level checker for the real-time counter: bus handshakes and event pulses.
 * Assumes it is bound to rtc_counter and sees only that module's ports.
 */
`timescale 1ns/1ps
module rtc_counter_asserts
    import rtc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wrap_event,
    input wire logic match_event,
    input wire logic periodic_irq
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("new read accepted while answer pending");
    a_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while answer pending");
    a_wrap_pulse: assert property (wrap_event |=> !wrap_event)
        else $error("wrap event longer than one cycle");
    a_match_pulse: assert property (match_event |=> !match_event)
        else $error("match event longer than one cycle");

    c_wrap: cover property (wrap_event);
    c_match: cover property (match_event);
    c_periodic: cover property ($rose(periodic_irq));
endmodule : rtc_counter_asserts

bind rtc_counter rtc_counter_asserts u_rtc_counter_asserts (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wrap_event, .match_event, .periodic_irq);

/* File: sim/rtc_counter_tb.sv */
/*
 * Self-checking bench for the real-time counter: register tasks over AXI4-Lite and directed tests.
 * Assumes the oscillator inputs are slow levels driven here, four mclk cycles per source period.
 */
`timescale 1ns/1ps
module rtc_counter_tb;
    import rtc_pkg::*;
    logic mclk, rst_n;
    logic [2:0] src;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic counter_irq, periodic_irq, wrap_event, match_event, periodic_out, pout_q, lvl_q;
    logic [EVT_N-1:0] periodic_level_evt;
    int err_count, checked, n_wrap, n_match, n_pout, n_lvl, w0, m0, p0;

    rtc_counter u_rtc_counter (.mclk, .rst_n, .xtal_clk(src[0]), .ext_clk(src[1]),
        .ultra_low_power_osc(src[2]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .counter_irq, .periodic_irq, .wrap_event, .match_event, .periodic_out,
        .periodic_level_evt);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Event monitors
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        pout_q <= periodic_out;
        lvl_q <= periodic_level_evt[0];
        if (wrap_event === 1'b1) n_wrap++;
        if (match_event === 1'b1) n_match++;
        if (periodic_out === 1'b1 && pout_q === 1'b0) n_pout++;
        if (periodic_level_evt[0] === 1'b1 && lvl_q === 1'b0) n_lvl++;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The response is taken late on purpose so that the slave must hold it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        repeat (2) @(posedge mclk);
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge mclk);
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        if (er == RESP_OKAY) chk(s_axi_rdata, exp);
    endtask : rd

    task automatic edges(input int s, input int n);
        repeat (n) begin
            src[s] <= 1'b1;
            repeat (2) @(posedge mclk);
            src[s] <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask : edges

    task automatic finish_test();
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        src = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OFS_WRAP_LIMIT, 32'h0000ffff);
        rd(OFS_MATCH_VALUE, 32'h0);
        rd(OFS_CONTROL_A, 32'h0);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'h1, RESP_SLVERR);
        rd(OFS_SYNC_STATUS, 32'h0);
        rd(OFS_PERIODIC_TIMER_SYNC_STATUS, 32'h0);
        wr(OFS_WRAP_LIMIT, 32'h3);
        wr(OFS_MATCH_VALUE, 32'h1);
        wr(OFS_IRQ_CONTROL, 32'h3);
        wr(OFS_CONTROL_A, 32'h1);
        rd(OFS_SYNC_STATUS, 32'h1);
        w0 = n_wrap;
        m0 = n_match;
        edges(0, 1);
        rd(OFS_SYNC_STATUS, 32'h0);
        rd(OFS_COUNT, 32'h1);
        rd(OFS_IRQ_FLAGS, 32'h0);
        edges(0, 1);
        rd(OFS_IRQ_FLAGS, 32'h2);
        chk({31'h0, counter_irq}, 32'h1);
        edges(0, 2);
        rd(OFS_COUNT, 32'h0);
        rd(OFS_IRQ_FLAGS, 32'h3);
        chk(32'(n_wrap - w0), 32'h1);
        chk(32'(n_match - m0), 32'h1);
        wr(OFS_IRQ_FLAGS, 32'h3);
        rd(OFS_IRQ_FLAGS, 32'h0);
        chk({31'h0, counter_irq}, 32'h0);
        wr(OFS_IRQ_CONTROL, 32'h0);
        edges(0, 2);
        rd(OFS_IRQ_FLAGS, 32'h2);
        chk({31'h0, counter_irq}, 32'h0);
        wr(OFS_IRQ_CONTROL, 32'h2);
        rd(OFS_COUNT, 32'h2);
        chk({31'h0, counter_irq}, 32'h1);
        wr(OFS_CONTROL_A, 32'h0);
        edges(0, 3);
        rd(OFS_COUNT, 32'h2);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_CONTROL_A, 32'h11);
        edges(0, 8);
        rd(OFS_COUNT, 32'h2);
        // The divided oscillator gives exactly one edge in any 32 oscillator edges.
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CONTROL_A, 32'h0);
            wr(OFS_CLOCK_SOURCE_SELECT, 32'(s));
            wr(OFS_COUNT, 32'h0);
            wr(OFS_CONTROL_A, 32'h1);
            edges(s == 0 ? 1 : 0, 1);
            edges(s == 3 ? 2 : s, s == 3 ? 32 : 1);
            rd(OFS_COUNT, 32'h1);
        end
        wr(OFS_CONTROL_A, 32'h0);
        wr(OFS_CLOCK_SOURCE_SELECT, 32'h1);
        wr(OFS_PERIODIC_IRQ_CONTROL, 32'h1);
        wr(OFS_PERIODIC_TIMER_CONTROL, 32'h9);
        // Enabling may raise the output at once; this read lets that edge be counted before the baseline.
        rd(OFS_PERIODIC_TIMER_SYNC_STATUS, 32'h1);
        p0 = n_pout;
        edges(1, 8);
        chk(32'(n_pout - p0), 32'h2);
        rd(OFS_PERIODIC_IRQ_FLAGS, 32'h1);
        chk({31'h0, periodic_irq}, 32'h1);
        rd(OFS_COUNT, 32'h1);
        wr(OFS_PERIODIC_IRQ_FLAGS, 32'h1);
        rd(OFS_PERIODIC_IRQ_FLAGS, 32'h0);
        chk({31'h0, periodic_irq}, 32'h0);
        wr(OFS_PERIODIC_TIMER_CONTROL, 32'h1);
        p0 = n_lvl;
        edges(1, 64);
        chk(32'(n_lvl - p0), 32'h1);
        wr(OFS_PERIODIC_TIMER_CONTROL, 32'h0);
        rd(OFS_PERIODIC_IRQ_FLAGS, 32'h0);
        chk({24'h0, periodic_level_evt}, 32'h0);
        chk({31'h0, periodic_out}, 32'h0);
        finish_test();
    end
endmodule : rtc_counter_tb
